/* File: rtl/pdmi_params.svh */
// register offsets, field positions, reset values and timing counts of the step indexer
`ifndef PDMI_PARAMS_SVH
`define PDMI_PARAMS_SVH

// byte offsets on the register bus
`define PDMI_OFS_CTRL      5'h00
`define PDMI_OFS_STATUS    5'h04
`define PDMI_OFS_INT_STAT  5'h08
`define PDMI_OFS_INT_MASK  5'h0c
`define PDMI_OFS_COIL      5'h10

// drive_control_reg fields
`define PDMI_CTRL_EDGE_BIT 0
`define PDMI_CTRL_RES_LSB  4
`define PDMI_CTRL_RES_MSB  7
`define PDMI_CTRL_RST      5'h00

// status register fields
`define PDMI_STAT_ANG_MSB  9
`define PDMI_STAT_STILL    16
`define PDMI_STAT_DIR      17
`define PDMI_STAT_STEP     18

// interrupt status and mask fields
`define PDMI_INT_STEP      0
`define PDMI_INT_STILL     1
`define PDMI_INT_RST       2'h0

// coil register: coil b starts here, coil a at bit 0
`define PDMI_COIL_B_LSB    16

// coarsest resolution code, one full step per event
`define PDMI_RES_MAX       4'h8

// standstill after this many clocks with no active step edge
`define PDMI_STILL_CYCLES  1048576

`endif

/* File: rtl/pdmi_pkg.sv */
// types shared by the step indexer modules
package pdmi_pkg;

    // control fields held in drive_control_reg
    typedef struct packed {
        logic [3:0] resolution_select;
        logic       both_edge_select;
    } pdmi_ctrl_t;

    // signed coil amplitudes, full scale is 248
    typedef struct packed {
        logic signed [8:0] coil_a;
        logic signed [8:0] coil_b;
    } pdmi_coil_t;

    // bus slave answer state
    typedef enum logic {
        BUS_IDLE   = 1'b0,
        BUS_ANSWER = 1'b1
    } pdmi_bus_state_t;

endpackage : pdmi_pkg

/* File: rtl/pdmi_sync.sv */
// three-stage synchroniser that accepts a change once the last two stages agree
`timescale 1ns/100ps

module pdmi_sync (
    input  wire logic clk,      // system clock
    input  wire logic rst_b,    // synchronised reset, active low
    input  wire logic ce,       // clock enable
    input  wire logic pin,      // asynchronous input pin
    output logic      level     // clean level in clk domain
);
    logic stage1;
    logic stage2;
    logic stage3;

    // first stage is read only by the second, to keep metastability contained
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            level  <= 1'b0;
        end else if (ce) begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                level <= stage3;
            end
        end
    end
endmodule : pdmi_sync

/* File: rtl/pdmi_sine_rom.sv */
// quarter-wave sine table with two combinational read ports
`timescale 1ns/100ps

module pdmi_sine_rom (
    input  wire logic [7:0] idx_a,   // table index for coil a
    input  wire logic [7:0] idx_b,   // table index for coil b
    output logic      [7:0] mag_a,   // magnitude for coil a
    output logic      [7:0] mag_b    // magnitude for coil b
);
    // each word holds 32 entries, entry 0 in the low byte; peak is 248
    localparam logic [255:0] QTAB [0:7] = '{
        256'h302e2d2b2a2827252422211f1e1c1b191816151311100e0d0b0a0807050402_01,
        256'h5e5d5b5a59575654535150_4f4d4c4a4947464443414_03e3d3c3a3937363433_31,
        256'h898887858483818_07f7e7c7b7a7877767473727_06f6d6c6b696867656462_6160,
        256'hafaeadacaaa9a8a7a6a5a4a3a1a09f9e9d9c9a99989796949392918f8e8d8c8a,
        256'hcecdcccbcac9c9c8c7c6c5c4c3c2c1c0bfbebdbcbbbab9b8b7b6b5b4b3b2b1b0,
        256'he5e4e4e3e2e2e1e1e0dfdfdedddcdcdbdadad9d8d7d7d6d5d4d4d3d2d1d0cfcf,
        256'hf3f3f2f2f2f1f1f1f0f0f0efefeeeeeeededececebebeaeae9e9e8e8e7e7e6e5,
        256'hf8f8f8f8f8f8f8f8f8f8f7f7f7f7f7f7f7f7f6f6f6f6f6f5f5f5f5f4f4f4f4f3
    };

    // one lookup, used by both ports
    function automatic logic [7:0] lookup(input logic [7:0] idx);
        logic [255:0] word;
        word = QTAB[idx[7:5]];
        return word[{idx[4:0], 3'h0} +: 8];
    endfunction : lookup

    // table entries rise monotonically from 1 to 248 [RL10] [RL11]
    assign mag_a = lookup(idx_a);
    assign mag_b = lookup(idx_b);
endmodule : pdmi_sine_rom

/* File: rtl/pdmi_indexer.sv */
// step and direction front end with microstep indexer and register slave
//
// Summary of operation
// RL1 - both-edge mode: every rising and falling step edge is a step event.
// RL2 - single-edge mode: only rising step edges count, falling ones ignored.
// RL3 - step and direction are synchronised to the system clock before use.
// RL4 - controller keeps step rate under a third (single) or quarter (both) of clock.
// RL5 - controller keeps full-step rate at or below clock divided by 512.
// RL6 - electrical angle is a 10-bit unsigned count over one electrical turn.
// RL7 - resolution field of drive control register picks the step size.
// RL8 - direction 0 adds the step size, direction 1 subtracts it.
// RL9 - one quarter sine table gives sine and cosine over a full turn.
// RL10 - table has 256 entries rising monotonically from 1 to 248.
// RL11 - no table entry exceeds 248, leaving headroom for an offset.
// RL12 - angles 0, 256, 512, 768 give the four half-step current pairs.
// RL13 - angles 128, 384, 640, 896 give 70.7 percent on both coils.
// RL14 - controller changes to coarse resolution only near coarse positions.
// RL15 - standstill flag rises after 2^20 clocks without step; next step clears.
// RL16 - top angle bit is coil a polarity: 0 forward, 1 reverse.
// RL17 - angle wraps modulo 1024 in both directions.
// RL18 - rising quadrants index directly, falling ones mirrored; quadrant gives sign.
// RL19 - step sizes are powers of two from 1 up to 256 for full steps.
`include "pdmi_params.svh"
`timescale 1ns/100ps

module pdmi_indexer #(
    parameter int unsigned STILL_CYCLES = `PDMI_STILL_CYCLES  // standstill timeout in clocks
) (
    input  wire logic                clk,                 // system clock, 40 mhz
    input  wire logic                rst_b,               // asynchronous reset, active low
    input  wire logic                ce,                  // clock enable, freezes state when low
    input  wire logic [4:0]          avs_address,         // byte address
    input  wire logic                avs_read,            // read request
    input  wire logic                avs_write,           // write request
    input  wire logic [31:0]         avs_writedata,       // write data
    input  wire logic [3:0]          avs_byteenable,      // write byte lanes
    output logic      [31:0]         avs_readdata,        // read data
    output logic                     avs_waitrequest,     // stall the master
    input  wire logic                step_pin,            // step pulse from controller
    input  wire logic                dir_pin,             // direction from controller
    output pdmi_pkg::pdmi_coil_t     coils,               // signed coil amplitudes
    output logic                     angle_polarity_bit,  // coil a polarity
    output logic                     standstill_flag,     // no step for the timeout
    output logic                     irq                  // level interrupt
);
    import pdmi_pkg::*;

    // reset release
    logic                 rst_q1;
    logic                 rst_sync_b;

    // bus slave
    pdmi_bus_state_t      bus_state;
    logic                 bus_req;
    logic                 bus_taken;
    logic                 wr_taken;
    logic [31:0]          wr_mask;
    logic [31:0]          next_readdata;

    // registers
    pdmi_ctrl_t           ctrl;
    logic [1:0]           int_status;
    logic [1:0]           int_mask;
    logic [1:0]           int_set;
    logic [1:0]           int_clr;

    // step path
    logic                 step_lvl;
    logic                 step_lvl_q;
    logic                 dir_lvl;
    logic                 step_event;
    logic [9:0]           step_size;
    logic [9:0]           electrical_angle;
    logic [9:0]           next_angle;

    // standstill
    logic [20:0]          still_cnt;
    logic                 still_hit;

    // coil path
    logic [9:0]           angle_b;
    logic [7:0]           idx_a;
    logic [7:0]           idx_b;
    logic [7:0]           mag_a;
    logic [7:0]           mag_b;
    pdmi_coil_t           next_coils;

    // power of two step from the resolution code, clamped at full step
    function automatic logic [9:0] step_of(input logic [3:0] res);
        logic [9:0] one;
        one = 10'h001;
        if (res >= `PDMI_RES_MAX) begin
            return 10'h100;
        end
        return one << res;
    endfunction : step_of

    // table index: direct in rising quadrants, mirrored in falling ones
    function automatic logic [7:0] index_of(input logic [9:0] ang);
        if (ang[8]) begin
            return ~ang[7:0];
        end
        return ang[7:0];
    endfunction : index_of

    // apply the quadrant sign to a table magnitude
    function automatic logic signed [8:0] signed_of(input logic neg, input logic [7:0] mag);
        logic signed [8:0] pos;
        pos = $signed({1'b0, mag});
        if (neg) begin
            return -pos;
        end
        return pos;
    endfunction : signed_of

    // byte-enable mask for partial writes
    function automatic logic [31:0] mask_of(input logic [3:0] be);
        logic [31:0] m;
        m = 32'h0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return m;
    endfunction : mask_of

    // reset is asserted at once and released two clocks later
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_q1     <= 1'b0;
            rst_sync_b <= 1'b0;
        end else if (ce) begin
            rst_q1     <= 1'b1;
            rst_sync_b <= rst_q1;
        end
    end

    // pins cross into the clock domain before any edge logic sees them
    pdmi_sync u_step_sync (
        .clk   (clk),
        .rst_b (rst_sync_b),
        .ce    (ce),
        .pin   (step_pin),
        .level (step_lvl)    // [RL3]
    );

    pdmi_sync u_dir_sync (
        .clk   (clk),
        .rst_b (rst_sync_b),
        .ce    (ce),
        .pin   (dir_pin),
        .level (dir_lvl)     // [RL3]
    );

    // ---- bus slave ----

    // every access waits one cycle, so read data can come from a flop
    assign bus_req         = avs_read | avs_write;
    assign avs_waitrequest = bus_req & (bus_state == BUS_IDLE);
    assign bus_taken       = bus_req & (bus_state == BUS_ANSWER);
    assign wr_taken        = bus_taken & avs_write;
    assign wr_mask         = mask_of(avs_byteenable);

    // read decode; unmapped offsets read zero
    always_comb begin
        next_readdata = 32'h0;
        if (avs_address == `PDMI_OFS_CTRL) begin
            next_readdata[`PDMI_CTRL_EDGE_BIT] = ctrl.both_edge_select;
            next_readdata[`PDMI_CTRL_RES_MSB:`PDMI_CTRL_RES_LSB] = ctrl.resolution_select;
        end else if (avs_address == `PDMI_OFS_STATUS) begin
            next_readdata[`PDMI_STAT_ANG_MSB:0] = electrical_angle;
            next_readdata[`PDMI_STAT_STILL] = standstill_flag;
            next_readdata[`PDMI_STAT_DIR]   = dir_lvl;
            next_readdata[`PDMI_STAT_STEP]  = step_lvl;
        end else if (avs_address == `PDMI_OFS_INT_STAT) begin
            next_readdata[1:0] = int_status;
        end else if (avs_address == `PDMI_OFS_INT_MASK) begin
            next_readdata[1:0] = int_mask;
        end else if (avs_address == `PDMI_OFS_COIL) begin
            next_readdata[8:0] = coils.coil_a;
            next_readdata[`PDMI_COIL_B_LSB +: 9] = coils.coil_b;
        end
    end

    // answer state and read data capture
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            bus_state    <= BUS_IDLE;
            avs_readdata <= 32'h0;
        end else if (ce) begin
            case (bus_state)
                BUS_IDLE: begin
                    if (bus_req) begin
                        bus_state    <= BUS_ANSWER;
                        avs_readdata <= next_readdata;
                    end
                end
                BUS_ANSWER: begin
                    bus_state <= BUS_IDLE;
                end
                default: begin
                    bus_state <= BUS_IDLE;
                end
            endcase
        end
    end

    // drive control register; the edge mode and step size steer the indexer
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ctrl <= `PDMI_CTRL_RST;
        end else if (ce && wr_taken && (avs_address == `PDMI_OFS_CTRL)) begin
            if (wr_mask[`PDMI_CTRL_EDGE_BIT]) begin
                ctrl.both_edge_select <= avs_writedata[`PDMI_CTRL_EDGE_BIT];
                ctrl.resolution_select <= avs_writedata[`PDMI_CTRL_RES_MSB:`PDMI_CTRL_RES_LSB];
            end
        end
    end

    // ---- step events and electrical angle ----

    // previous clean step level for edge detection
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            step_lvl_q <= 1'b0;
        end else if (ce) begin
            step_lvl_q <= step_lvl;
        end
    end

    // both-edge mode takes any change, otherwise rising only
    always_comb begin
        if (ctrl.both_edge_select) begin
            step_event = step_lvl ^ step_lvl_q;              // [RL1]
        end else begin
            step_event = step_lvl & ~step_lvl_q;             // [RL2]
        end
    end

    assign step_size = step_of(ctrl.resolution_select);  // [RL7] [RL19]

    // 10-bit sum wraps naturally in either direction
    always_comb begin
        if (dir_lvl) begin
            next_angle = electrical_angle - step_size;       // [RL8] [RL17]
        end else begin
            next_angle = electrical_angle + step_size;       // [RL8] [RL17]
        end
    end

    // angle counter; resolution changes take effect on the next event only
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            electrical_angle <= 10'h000;
        end else if (ce && step_event) begin
            electrical_angle <= next_angle;                  // [RL6]
        end
    end

    // ---- standstill detection ----

    assign still_hit = (still_cnt == 21'(STILL_CYCLES - 1));

    // counter parks once the flag is up, so it never wraps
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            still_cnt       <= 21'h0;
            standstill_flag <= 1'b0;
        end else if (ce) begin
            if (step_event) begin
                still_cnt       <= 21'h0;
                standstill_flag <= 1'b0;                     // [RL15]
            end else if (!standstill_flag) begin
                if (still_hit) begin
                    standstill_flag <= 1'b1;                 // [RL15]
                end else begin
                    still_cnt <= still_cnt + 21'h1;
                end
            end
        end
    end

    // ---- coil amplitudes ----

    // cosine is sine a quarter turn ahead
    assign angle_b = electrical_angle + 10'h100;             // [RL9]
    assign idx_a   = index_of(electrical_angle);             // [RL18]
    assign idx_b   = index_of(angle_b);                      // [RL18]

    pdmi_sine_rom u_rom (
        .idx_a (idx_a),
        .idx_b (idx_b),
        .mag_a (mag_a),
        .mag_b (mag_b)
    );

    // upper half turn is negative current
    always_comb begin
        next_coils.coil_a = signed_of(electrical_angle[9], mag_a);  // [RL12] [RL13] [RL16]
        next_coils.coil_b = signed_of(angle_b[9], mag_b);           // [RL12] [RL13]
    end

    // coils lag the angle by one clock to keep the table off the pins
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            coils <= '0;
        end else if (ce) begin
            coils <= next_coils;
        end
    end

    assign angle_polarity_bit = electrical_angle[9];         // [RL16]

    // ---- interrupts ----

    assign int_set[`PDMI_INT_STEP]  = step_event;
    assign int_set[`PDMI_INT_STILL] = ~standstill_flag & still_hit & ~step_event;

    // write one to clear
    always_comb begin
        int_clr = 2'h0;
        if (wr_taken && (avs_address == `PDMI_OFS_INT_STAT) && wr_mask[0]) begin
            int_clr = avs_writedata[1:0];
        end
    end

    // a set in the clearing cycle wins, so no event is lost
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            int_status <= `PDMI_INT_RST;
        end else if (ce) begin
            int_status <= (int_status & ~int_clr) | int_set;
        end
    end

    // interrupt mask register
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            int_mask <= `PDMI_INT_RST;
        end else if (ce && wr_taken && (avs_address == `PDMI_OFS_INT_MASK) && wr_mask[0]) begin
            int_mask <= avs_writedata[1:0];
        end
    end

    assign irq = |(int_status & int_mask);
endmodule : pdmi_indexer

/* File: test/pdmi_indexer_checker.sv */
// port checks for the step indexer
`timescale 1ns/100ps

module pdmi_indexer_checker #(
    parameter int unsigned STILL_CYCLES = 64  // standstill timeout
) (
    input wire logic                 clk,                 // clock
    input wire logic                 rst_b,               // reset, active low
    input wire logic                 ce,                  // clock enable
    input wire logic                 avs_read,            // read request
    input wire logic                 avs_write,           // write request
    input wire logic                 avs_waitrequest,     // stall
    input wire logic                 step_pin,            // step pin
    input wire pdmi_pkg::pdmi_coil_t coils,               // amplitudes
    input wire logic                 angle_polarity_bit,  // polarity
    input wire logic                 standstill_flag      // standstill
);
    import pdmi_pkg::*;
    int unsigned q_any;   // clocks since reset or any step pin change
    int unsigned q_rise;  // clocks since reset or a rising step pin
    logic        step_q;  // step pin a clock ago
    logic [8:0]  mag_a;   // coil a magnitude
    logic [8:0]  mag_b;   // coil b magnitude

    // magnitudes of the signed amplitudes
    assign mag_a = coils.coil_a[8] ? 9'(-coils.coil_a) : coils.coil_a;
    assign mag_b = coils.coil_b[8] ? 9'(-coils.coil_b) : coils.coil_b;

    // idle counters saturate so a long pause cannot wrap them
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q_any  <= 0;
            q_rise <= 0;
            step_q <= 1'b0;
        end else if (ce) begin
            step_q <= step_pin;
            q_any  <= (step_pin != step_q) ? 0 : (q_any < STILL_CYCLES + 16) ? q_any + 1 : q_any;
            q_rise <= (step_pin && !step_q) ? 0 : (q_rise < STILL_CYCLES + 16) ? q_rise + 1 : q_rise;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_stall;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_answer;
        (avs_read || avs_write) && !avs_waitrequest;
    endsequence

    AST_WAIT_ONE: assert property (s_stall |=> s_answer)
        else $error("waitrequest not low one cycle after request");
    AST_WAIT_REQ: assert property (avs_waitrequest |-> avs_read || avs_write)
        else $error("waitrequest without request");
    AST_POLARITY: assert property (coils != '0 |-> coils.coil_a[8] == $past(angle_polarity_bit))
        else $error("coil a sign differs from polarity bit");
    AST_RANGE: assert property (coils != '0 |-> mag_a inside {[1:248]} && mag_b inside {[1:248]})
        else $error("coil magnitude outside table range");
    AST_QUAD: assert property (coils != '0 |-> mag_a >= 175 || mag_b >= 175)
        else $error("coil pair not in quadrature");
    AST_STILL_MIN: assert property ($rose(standstill_flag) |-> q_rise >= STILL_CYCLES)
        else $error("standstill raised too early");
    AST_STILL_MAX: assert property (q_any == STILL_CYCLES + 10 |-> standstill_flag)
        else $error("standstill missing after idle spell");
    AST_STILL_CLR: assert property ($fell(standstill_flag) |-> q_any <= 6)
        else $error("standstill cleared without step edge");
    AST_COIL_CAUSE: assert property ($changed(coils) |-> q_any inside {[2:8]})
        else $error("coils moved without a synchronised step");
endmodule : pdmi_indexer_checker

bind pdmi_indexer pdmi_indexer_checker #(.STILL_CYCLES(STILL_CYCLES)) chk_u (
    .clk(clk), .rst_b(rst_b), .ce(ce), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .step_pin(step_pin), .coils(coils),
    .angle_polarity_bit(angle_polarity_bit), .standstill_flag(standstill_flag));

/* File: test/pdmi_step_ctrl.sv */
// behavioural motion controller driving step and direction
`timescale 1ns/100ps

module pdmi_step_ctrl (
    input  wire logic clk,       // system clock
    output logic      step_pin,  // step pulse, idles low
    output logic      dir_pin    // direction level
);
    initial begin
        step_pin = 1'b0;
        dir_pin  = 1'b0;
    end

    // n pulses in direction d at microstep size sz
    task automatic move(input logic d, input int n, input int sz);
        int hold;
        // slow edges: rate far below the clock, full steps no faster than clock/512
        hold = (2 * sz > 6) ? 2 * sz : 6;
        @(posedge clk);
        dir_pin <= d;
        // direction settles well ahead of the first edge
        repeat (4) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            step_pin <= 1'b1;
            repeat (hold) @(posedge clk);
            step_pin <= 1'b0;
            repeat (hold) @(posedge clk);
        end
    endtask : move
endmodule : pdmi_step_ctrl

/* File: test/tb_pulse_direction_microstep_indexer.sv */
// self-checking bench for the step indexer
`timescale 1ns/100ps
`include "pdmi_params.svh"

module tb_pulse_direction_microstep_indexer;
    import pdmi_pkg::*;
    localparam int unsigned STILL = 64;  // short timeout in sim
    localparam int EA[8] = '{1, 176, 248, 175, -1, -176, -248, -175};
    localparam int EB[8] = '{248, 175, -1, -176, -248, -175, 1, 176};
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        ce = 1'b1;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        step_pin;
    logic        dir_pin;
    pdmi_coil_t  coils;
    logic        angle_polarity_bit;
    logic        standstill_flag;
    logic        irq;
    logic [31:0] rd;
    int          n_fail = 0;
    int          n_tests = 0;
    int          angle = 0;  // expected electrical angle

    initial begin
        forever #12.5 clk = ~clk;
    end

    pdmi_indexer #(.STILL_CYCLES(STILL)) dut_u (
        .clk(clk), .rst_b(rst_b), .ce(ce), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .step_pin(step_pin), .dir_pin(dir_pin), .coils(coils),
        .angle_polarity_bit(angle_polarity_bit), .standstill_flag(standstill_flag), .irq(irq));

    pdmi_step_ctrl ctrl_u (.clk(clk), .step_pin(step_pin), .dir_pin(dir_pin));

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // one access; request held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
        int t;
        t = 0;
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= wd;
        avs_read      <= !wr;
        avs_write     <= wr;
        do begin
            @(posedge clk);
            t++;
        end while (avs_waitrequest !== 1'b0 && t < 100);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        chk("bus_answer", 32'h1, 32'(t < 100));
    endtask : bus

    task automatic do_reset;
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        // internal reset copy needs two more edges
        repeat (3) @(posedge clk);
        angle = 0;
    endtask : do_reset

    // step via the partner, track the angle
    task automatic step(input logic d, input int n, input int ev, input int sz);
        ctrl_u.move(d, n, sz);
        angle = (angle + (d ? -ev : ev) * n * sz) & 1023;
    endtask : step

    task automatic chk_pos(input int a, input int b);
        bus(1'b0, `PDMI_OFS_STATUS, 32'h0);
        chk("angle", 32'(angle), {22'h0, rd[9:0]});
        chk("polarity", 32'(angle[9]), 32'(angle_polarity_bit));
        chk("coil_a", 32'(a), 32'(coils.coil_a));
        chk("coil_b", 32'(b), 32'(coils.coil_b));
        bus(1'b0, `PDMI_OFS_COIL, 32'h0);
        chk("coil_reg", {7'h0, 9'(b), 7'h0, 9'(a)}, rd);
    endtask : chk_pos

    // reset values, unmapped and read-only places
    task automatic t_reset;
        bus(1'b0, `PDMI_OFS_CTRL, 32'h0);
        chk("ctrl", 32'h0, rd);
        bus(1'b0, `PDMI_OFS_INT_MASK, 32'h0);
        chk("mask", 32'h0, rd);
        bus(1'b1, 5'h14, 32'hffff_ffff);
        bus(1'b0, 5'h14, 32'h0);
        chk("unmapped", 32'h0, rd);
        bus(1'b1, `PDMI_OFS_STATUS, 32'h3ff);
        chk_pos(1, 248);
    endtask : t_reset

    task automatic t_single;
        bus(1'b1, `PDMI_OFS_CTRL, 32'h40);
        step(1'b0, 3, 1, 16);
        chk_pos(73, 237);
    endtask : t_single

    task automatic t_both;
        bus(1'b1, `PDMI_OFS_CTRL, 32'h41);
        step(1'b1, 2, 2, 16);
        chk_pos(-24, 247);
    endtask : t_both

    // resolution codes 0 to 9, clamping past the top
    task automatic t_res;
        for (int c = 0; c <= 9; c++) begin
            bus(1'b1, `PDMI_OFS_CTRL, 32'(c) << 4);
            step(1'b0, 1, 1, (c >= 8) ? 256 : (1 << c));
            bus(1'b0, `PDMI_OFS_STATUS, 32'h0);
            chk("angle_res", 32'(angle), {22'h0, rd[9:0]});
        end
    endtask : t_res

    // align finely, then half steps round a full turn
    task automatic t_half;
        bus(1'b1, `PDMI_OFS_CTRL, 32'h0);
        step(1'b0, (1024 + 768 - angle) % 1024, 1, 1);
        bus(1'b1, `PDMI_OFS_CTRL, 32'h70);
        for (int k = 0; k < 8; k++) begin
            chk_pos(EA[angle >> 7], EB[angle >> 7]);
            step(1'b0, 1, 1, 128);
        end
    endtask : t_half

    task automatic t_irq;
        bus(1'b1, `PDMI_OFS_CTRL, 32'h0);
        bus(1'b1, `PDMI_OFS_INT_STAT, 32'h3);
        bus(1'b1, `PDMI_OFS_INT_MASK, 32'h1);
        bus(1'b0, `PDMI_OFS_INT_STAT, 32'h0);
        chk("int_clear", 32'h0, rd);
        chk("irq_idle", 32'h0, 32'(irq));
        step(1'b0, 1, 1, 1);
        chk("still_clr", 32'h0, 32'(standstill_flag));
        chk("irq_step", 32'h1, 32'(irq));
        repeat (STILL + 12) @(posedge clk);
        chk("still_set", 32'h1, 32'(standstill_flag));
        bus(1'b0, `PDMI_OFS_INT_STAT, 32'h0);
        chk("int_both", 32'h3, rd);
        bus(1'b1, `PDMI_OFS_INT_STAT, 32'h1);
        @(posedge clk);
        chk("irq_masked", 32'h0, 32'(irq));
        bus(1'b1, `PDMI_OFS_INT_MASK, 32'h2);
        @(posedge clk);
        chk("irq_still", 32'h1, 32'(irq));
        bus(1'b1, `PDMI_OFS_INT_STAT, 32'h2);
        @(posedge clk);
        chk("irq_cleared", 32'h0, 32'(irq));
    endtask : t_irq

    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    // the tests take some 8000 clocks
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        results();
    end

    initial begin
        do_reset();
        t_reset();
        t_single();
        t_both();
        t_res();
        t_half();
        t_irq();
        ce <= 1'b0;
        ctrl_u.move(1'b0, 1, 1);
        ce <= 1'b1;
        chk_pos(-248, 2);
        do_reset();
        chk_pos(1, 248);
        results();
    end
endmodule : tb_pulse_direction_microstep_indexer
